// file: shared/etc_map.svh
// register offsets, field positions, reset values for the 8-bit timer
// assumes an Avalon-MM slave with word addressing by byte offset / 4
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH
`define ETC_OFS_CTRL 4'h0
`define ETC_OFS_CNT 4'h1
`define ETC_OFS_CMP 4'h2
`define ETC_OFS_FLAG 4'h3
`define ETC_OFS_MASK 4'h4
`define ETC_OFS_STAT 4'h5
`define ETC_CTRL_CS_LO 0
`define ETC_CTRL_WGM_LO 3
`define ETC_CTRL_COM_LO 5
`define ETC_CTRL_FOC 7
`define ETC_FLAG_OVF 0
`define ETC_FLAG_CMF 1
`define ETC_MASK_CMIE 1
`define ETC_MASK_OVIE 0
`define ETC_STAT_GIE 0
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hFF
`define ETC_RST_BYTE 8'h00
`define ETC_PRE_W 10
`endif

// file: shared/etc_pkg.sv
// types shared by the timer top and its tick selector
package etc_pkg;
    typedef enum logic [3:0] {
        ETC_MODE_NORMAL = 4'b0001,
        ETC_MODE_PCPWM = 4'b0010,
        ETC_MODE_CTC = 4'b0100,
        ETC_MODE_FPWM = 4'b1000
    } etc_mode_t;
    typedef logic [7:0] etc_byte_t;
endpackage : etc_pkg

// file: shared/etc_tick_if.sv
// tick request and tick answer between the top and the tick selector
`timescale 1ns/1ps
interface etc_tick_if;
    logic [2:0] sel;
    logic ext_pin;
    logic tick;
    modport top (output sel, output ext_pin, input tick);
    modport sel_end (input sel, input ext_pin, output tick);
endinterface : etc_tick_if

// file: src/etc_tick_sel.sv
// prescaler and clock select; one-cycle tick enable
// assumes ext_pin synchronous to core_clk
`timescale 1ns/1ps
`include "etc_map.svh"
module etc_tick_sel
    import etc_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst, // sync reset
    etc_tick_if.sel_end tk // select and tick
);
    logic [`ETC_PRE_W-1:0] pre_r;
    logic ext_d_r;
    logic tick_r;
    logic pre_hit;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= tk.ext_pin;
        end
    end

    always_comb begin
        case (tk.sel)
            3'd1: pre_hit = 1'b1;
            3'd2: pre_hit = (pre_r[2:0] == 3'h7);
            3'd3: pre_hit = (pre_r[5:0] == 6'h3F);
            3'd4: pre_hit = (pre_r[7:0] == 8'hFF);
            3'd5: pre_hit = (pre_r == 10'h3FF);
            3'd6: pre_hit = ext_d_r & ~tk.ext_pin;
            3'd7: pre_hit = ~ext_d_r & tk.ext_pin;
            default: pre_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= pre_hit && (tk.sel != 3'd0);
        end
    end
    assign tk.tick = tick_r;
endmodule : etc_tick_sel

// file: src/etc_timer.sv
// 8-bit timer with one compare channel, Avalon-MM register slave
// assumes processor core as bus master; ext pin synchronous
`timescale 1ns/1ps
`include "etc_map.svh"
module etc_timer
    import etc_pkg::*;
(
    input wire logic core_clk, // 200 MHz system clock
    input wire logic rst, // sync reset, active high
    input wire logic [3:0] avs_address, // word index
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic ext_count_pin, // external count pin
    input wire logic ovf_irq_ack, // overflow interrupt taken
    input wire logic cmp_irq_ack, // compare interrupt taken
    output logic compare_output, // compare output state
    output logic overflow_irq, // overflow request
    output logic compare_irq // compare request
);
    etc_tick_if tk ();
    etc_byte_t ctrl_r, counter_value_r, compare_value_r, cmp_buf_r;
    logic ovf_r, cmf_r, cmie_r, ovie_r, gie_r, dir_down_r, block_r;
    logic oc_r, ack_r, wait_r, ovf_irq_r, cmp_irq_r;
    logic chk_wr_pend_r;
    logic [31:0] rdata_r;
    etc_mode_t mode;
    logic tick, is_bottom, is_max, match, at_top, pwm;
    logic wr_cnt, wr_cmp, wr_ctrl, wr_flag, eff_match, force_m;
    logic cnt_clear, ovf_set;
    etc_byte_t cnt_nxt;
    logic [1:0] com;

    // ========================================================
    // tick selection
    assign tk.sel = ctrl_r[`ETC_CTRL_CS_LO+:3];
    assign tk.ext_pin = ext_count_pin;
    assign tick = tk.tick;
    etc_tick_sel u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tk(tk)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction : hit

    // ========================================================
    // bus slave: one wait cycle then answer
    wire access = (avs_read | avs_write) & ~ack_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            wait_r <= 1'b1;
        end else begin
            ack_r <= access;
            wait_r <= ~access;
        end
    end
    // stall straight from a flop, always the inverse of ack_r
    assign avs_waitrequest = wait_r;
    wire wr_go = avs_write & ack_r;
    assign wr_ctrl = wr_go & hit(avs_address, `ETC_OFS_CTRL);
    assign wr_cnt = wr_go & hit(avs_address, `ETC_OFS_CNT);
    assign wr_cmp = wr_go & hit(avs_address, `ETC_OFS_CMP);
    assign wr_flag = wr_go & hit(avs_address, `ETC_OFS_FLAG);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read & ~ack_r) begin
            if (hit(avs_address, `ETC_OFS_CTRL)) begin
                rdata_r <= {24'h00_0000, 1'b0, ctrl_r[6:0]};
            end else if (hit(avs_address, `ETC_OFS_CNT)) begin
                rdata_r <= {24'h00_0000, counter_value_r};
            end else if (hit(avs_address, `ETC_OFS_CMP)) begin
                rdata_r <= {24'h00_0000, pwm ? cmp_buf_r : compare_value_r};
            end else if (hit(avs_address, `ETC_OFS_FLAG)) begin
                rdata_r <= {30'h0000_0000, cmf_r, ovf_r};
            end else if (hit(avs_address, `ETC_OFS_MASK)) begin
                rdata_r <= {30'h0000_0000, cmie_r, ovie_r};
            end else if (hit(avs_address, `ETC_OFS_STAT)) begin
                rdata_r <= {30'h0000_0000, oc_r, gie_r};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end
    assign avs_readdata = rdata_r;

    // ========================================================
    // control registers
    // action field takes effect at once
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= `ETC_RST_BYTE;
            cmie_r <= 1'b0;
            ovie_r <= 1'b0;
            gie_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {1'b0, avs_writedata[6:0]};
            end
            if (wr_go & hit(avs_address, `ETC_OFS_MASK)) begin
                cmie_r <= avs_writedata[`ETC_MASK_CMIE];
                ovie_r <= avs_writedata[`ETC_MASK_OVIE];
            end
            if (wr_go & hit(avs_address, `ETC_OFS_STAT)) begin
                gie_r <= avs_writedata[`ETC_STAT_GIE];
            end
        end
    end
    assign com = ctrl_r[`ETC_CTRL_COM_LO+:2];

    always_comb begin
        case (ctrl_r[`ETC_CTRL_WGM_LO+:2])
            2'd1: mode = ETC_MODE_PCPWM;
            2'd2: mode = ETC_MODE_CTC;
            2'd3: mode = ETC_MODE_FPWM;
            default: mode = ETC_MODE_NORMAL;
        endcase
    end
    assign pwm = (mode == ETC_MODE_PCPWM) || (mode == ETC_MODE_FPWM);

    // ========================================================
    // counter
    // bottom detect
    assign is_bottom = (counter_value_r == `ETC_BOTTOM);
    assign is_max = (counter_value_r == `ETC_MAX);
    assign match = (counter_value_r == compare_value_r);
    // top is compare value in clear-on-match, else max
    assign at_top = (mode == ETC_MODE_CTC) ? match : is_max;
    assign cnt_clear = (mode == ETC_MODE_CTC) && match;

    // clear, up or down per mode
    always_comb begin
        cnt_nxt = counter_value_r;
        if (cnt_clear) begin
            cnt_nxt = `ETC_BOTTOM;
        end else if (mode == ETC_MODE_PCPWM) begin
            if (dir_down_r ? !is_bottom : is_max) begin
                cnt_nxt = counter_value_r - 8'h01;
            end else begin
                cnt_nxt = counter_value_r + 8'h01;
            end
        end else begin
            cnt_nxt = counter_value_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            counter_value_r <= `ETC_RST_BYTE;
        end else if (wr_cnt) begin
            counter_value_r <= avs_writedata[7:0];
        end else if (tick) begin
            counter_value_r <= cnt_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_down_r <= 1'b0;
        end else if (mode != ETC_MODE_PCPWM) begin
            dir_down_r <= 1'b0;
        end else if (tick) begin
            if (is_max) begin
                dir_down_r <= 1'b1;
            end else if (is_bottom) begin
                dir_down_r <= 1'b0;
            end
        end
    end

    // block compare match on next tick after counter write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            block_r <= 1'b0;
        end else if (wr_cnt) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end
    assign eff_match = tick && match && !block_r && !wr_cnt;

    // ========================================================
    // compare register and buffer
    // load at max in PWM modes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            compare_value_r <= `ETC_RST_BYTE;
            cmp_buf_r <= `ETC_RST_BYTE;
        end else begin
            if (wr_cmp) begin
                cmp_buf_r <= avs_writedata[7:0];
            end
            if (wr_cmp && !pwm) begin
                compare_value_r <= avs_writedata[7:0];
            end else if (pwm && tick) begin
                if (is_max) begin
                    compare_value_r <= cmp_buf_r;
                end
            end
        end
    end

    // ========================================================
    // flags
    // overflow point per mode
    assign ovf_set = tick && ((mode == ETC_MODE_PCPWM) ?
        (is_bottom && dir_down_r) : is_max);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_r <= 1'b1;
        end else if (ovf_irq_ack ||
                     (wr_flag && avs_writedata[`ETC_FLAG_OVF])) begin
            ovf_r <= 1'b0;
        end
    end

    // clear by ack or one written, set wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmf_r <= 1'b0;
        end else if (eff_match) begin
            cmf_r <= 1'b1;
        end else if (cmp_irq_ack ||
                     (wr_flag && avs_writedata[`ETC_FLAG_CMF])) begin
            cmf_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_irq_r <= 1'b0;
            cmp_irq_r <= 1'b0;
        end else begin
            ovf_irq_r <= ovf_r & ovie_r & gie_r & ~ovf_irq_ack;
            cmp_irq_r <= cmf_r & cmie_r & gie_r & ~cmp_irq_ack;
        end
    end
    assign overflow_irq = ovf_irq_r;
    assign compare_irq = cmp_irq_r;

    // ========================================================
    // compare output
    // force strobe in non-PWM
    assign force_m = wr_ctrl && avs_writedata[`ETC_CTRL_FOC] && !pwm;
    // action decode, shared by forced and non-PWM matches
    function automatic logic act_out(input logic [1:0] c, input logic cur);
        case (c)
            2'd1: act_out = ~cur;
            2'd2: act_out = 1'b0;
            2'd3: act_out = 1'b1;
            default: act_out = cur;
        endcase
    endfunction : act_out

    always_ff @(posedge core_clk) begin
        if (rst) begin
            oc_r <= 1'b0;
        // forced action uses the field written with it
        end else if (force_m) begin
            oc_r <= act_out(avs_writedata[`ETC_CTRL_COM_LO+:2], oc_r);
        end else if (com != 2'd0) begin
            if (!pwm && eff_match) begin
                oc_r <= act_out(com, oc_r);
            end else if (mode == ETC_MODE_FPWM && tick) begin
                // clear on match, set at wrap to bottom; inverted for action 3
                if (eff_match) begin
                    oc_r <= (com == 2'd3);
                end else if (is_max) begin
                    oc_r <= (com != 2'd3);
                end
            end else if (mode == ETC_MODE_PCPWM && eff_match) begin
                oc_r <= (com == 2'd3) ^ dir_down_r;
            end
        end
    end
    assign compare_output = oc_r;

    // ========================================================
    // checks
    // select zero for two cycles flushes the tick pipeline
    sequence s_stopped;
        (tk.sel == 3'd0) ##1 (tk.sel == 3'd0 && !wr_cnt);
    endsequence
    property p_stop;
        @(posedge core_clk) disable iff (rst)
        s_stopped |=> $stable(counter_value_r);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved stopped");
    property p_wrwin;
        @(posedge core_clk) disable iff (rst)
        wr_cnt |=> counter_value_r == $past(avs_writedata[7:0]);
    endproperty
    a_wrwin: assert property (p_wrwin) else $error("write lost");
    // helper: a counter write waits for its first tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chk_wr_pend_r <= 1'b0;
        end else if (wr_cnt) begin
            chk_wr_pend_r <= 1'b1;
        end else if (tick) begin
            chk_wr_pend_r <= 1'b0;
        end
    end
    sequence s_first_tick;
        chk_wr_pend_r && tick && !wr_cnt;
    endsequence
    property p_block;
        @(posedge core_clk) disable iff (rst)
        s_first_tick |=> !$rose(cmf_r);
    endproperty
    a_block: assert property (p_block) else $error("match not blocked");
    property p_cmf;
        @(posedge core_clk) disable iff (rst)
        eff_match |=> cmf_r;
    endproperty
    a_cmf: assert property (p_cmf) else $error("match flag missed");
    property p_wrap;
        @(posedge core_clk) disable iff (rst)
        (mode == ETC_MODE_NORMAL && tick && is_max && !wr_cnt) |=>
            (counter_value_r == 8'h00 && ovf_r);
    endproperty
    a_wrap: assert property (p_wrap) else $error("normal wrap");
    property p_ctc;
        @(posedge core_clk) disable iff (rst)
        (mode == ETC_MODE_CTC && tick && match && !wr_cnt) |=>
            counter_value_r == 8'h00;
    endproperty
    a_ctc: assert property (p_ctc) else $error("ctc no clear");
    property p_irq;
        @(posedge core_clk) disable iff (rst)
        compare_irq |-> $past(cmf_r & cmie_r & gie_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not gated");
    property p_com0;
        @(posedge core_clk) disable iff (rst)
        (com == 2'd0 && !force_m) |=> $stable(oc_r);
    endproperty
    a_com0: assert property (p_com0) else $error("output moved");
endmodule : etc_timer

// file: tb/etc_cpu_model.sv
// processor core model: Avalon-MM master and interrupt acknowledge
// assumes the slave answers with waitrequest low; every wait is bounded
`timescale 1ns/1ps
module etc_cpu_model
    import etc_pkg::*;
(
    input wire logic core_clk, // system clock
    output logic [3:0] avs_address, // word index
    output logic avs_read, // read request
    output logic avs_write, // write request
    output logic [31:0] avs_writedata, // write data
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    output logic ovf_irq_ack, // overflow taken
    output logic cmp_irq_ack, // compare taken
    output logic bus_hang // access never answered
);
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        ovf_irq_ack = 1'b0;
        cmp_irq_ack = 1'b0;
        bus_hang = 1'b0;
    end

    // ==========================================
    // bus access, held until waitrequest low
    task automatic access(input logic is_wr, input logic [3:0] a,
                          input etc_byte_t d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read <= ~is_wr;
        avs_write <= is_wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) begin
            bus_hang <= 1'b1;
        end
    endtask : access

    // ==========================================
    // interrupt taken pulse
    task automatic take_irq(input logic ovf);
        @(posedge core_clk);
        ovf_irq_ack <= ovf;
        cmp_irq_ack <= ~ovf;
        @(posedge core_clk);
        ovf_irq_ack <= 1'b0;
        cmp_irq_ack <= 1'b0;
    endtask : take_irq
endmodule : etc_cpu_model

// file: tb/test_eight_bit_timer_compare_unit.sv
// self-checking bench for the 8-bit timer, one task per scenario
// assumes ext pin pulses of 6 cycles are seen as one tick each
`timescale 1ns/1ps
`include "etc_map.svh"
module test_eight_bit_timer_compare_unit
    import etc_pkg::*;
;
    localparam logic [3:0] CTL = `ETC_OFS_CTRL;
    localparam logic [3:0] CNT = `ETC_OFS_CNT;
    localparam logic [3:0] CMP = `ETC_OFS_CMP;
    localparam logic [3:0] FLG = `ETC_OFS_FLAG;
    localparam logic [3:0] MSK = `ETC_OFS_MASK;
    localparam logic [3:0] STA = `ETC_OFS_STAT;
    logic core_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic ext_count_pin, ovf_irq_ack, cmp_irq_ack, bus_hang;
    logic compare_output, overflow_irq, compare_irq;
    int err_count, n_tests;

    etc_timer u_etc_timer (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .ext_count_pin, .ovf_irq_ack, .cmp_irq_ack, .compare_output,
        .overflow_irq, .compare_irq);
    etc_cpu_model u_etc_cpu_model (.core_clk, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .ovf_irq_ack, .cmp_irq_ack, .bus_hang);

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // ==========================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [3:0] a, input etc_byte_t d);
        u_etc_cpu_model.access(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input etc_byte_t e);
        u_etc_cpu_model.access(1'b0, a, 8'h00, q);
        check(q, {24'h00_0000, e}, "register");
    endtask : rd_chk

    task automatic pin_pulse(input int n);
        repeat (n) begin
            @(posedge core_clk);
            ext_count_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            ext_count_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask : pin_pulse

    function automatic etc_byte_t cb(input logic [2:0] cs,
        input logic [1:0] wgm, input logic [1:0] com, input logic foc);
        return {foc, com, wgm, cs};
    endfunction : cb

    // ==========================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 6; i++) rd_chk(4'(i), 8'h00);
        rd_chk(4'hF, 8'h00); // unmapped index
        check(compare_output, 1'b0, "output at reset");
        wr(CNT, 8'h12);
        pin_pulse(2);
        rd_chk(CNT, 8'h12);
    endtask : t_reset

    task automatic t_edges();
        for (int cs = 6; cs < 8; cs++) begin
            wr(CTL, cb(3'(cs), 2'h0, 2'h0, 1'b0));
            wr(CNT, 8'h30);
            @(posedge core_clk);
            ext_count_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            rd_chk(CNT, (cs == 7) ? 8'h31 : 8'h30);
            ext_count_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
            rd_chk(CNT, 8'h31);
        end
        wr(CTL, 8'h00);
    endtask : t_edges

    task automatic t_prescale();
        int dv[5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(CNT, 8'h00);
            wr(CTL, cb(3'(i + 1), 2'h0, 2'h0, 1'b0));
            repeat (dv[i] * 4) @(posedge core_clk);
            wr(CTL, 8'h00);
            u_etc_cpu_model.access(1'b0, CNT, 8'h00, q);
            check(q >= 3 && q <= 8, 1'b1, "prescaled ticks");
        end
        // counter write lands on a tick edge, four ticks drain after it
        wr(CTL, cb(3'h1, 2'h0, 2'h0, 1'b0));
        wr(CNT, 8'h40);
        wr(CTL, 8'h00);
        rd_chk(CNT, 8'h44);
    endtask : t_prescale

    task automatic t_normal();
        wr(FLG, 8'h03);
        wr(MSK, 8'h01);
        wr(STA, 8'h01);
        wr(CNT, 8'hFE);
        wr(CTL, cb(3'h7, 2'h0, 2'h0, 1'b0));
        pin_pulse(1);
        rd_chk(FLG, 8'h00);
        pin_pulse(1);
        rd_chk(CNT, 8'h00);
        rd_chk(FLG, 8'h01);
        check(overflow_irq, 1'b1, "overflow request");
        u_etc_cpu_model.take_irq(1'b1);
        repeat (2) @(posedge core_clk);
        rd_chk(FLG, 8'h00);
        check(overflow_irq, 1'b0, "overflow request");
    endtask : t_normal

    task automatic t_match();
        wr(CTL, 8'h00);
        wr(CMP, 8'h05);
        wr(CNT, 8'h05);
        wr(FLG, 8'h03);
        wr(MSK, 8'h02);
        wr(STA, 8'h00);
        wr(CTL, cb(3'h7, 2'h0, 2'h0, 1'b0));
        pin_pulse(1);
        rd_chk(FLG, 8'h00);
        wr(CNT, 8'h03);
        pin_pulse(2);
        rd_chk(FLG, 8'h00);
        pin_pulse(1);
        rd_chk(FLG, 8'h02);
        check(compare_irq, 1'b0, "compare request");
        wr(STA, 8'h01);
        repeat (3) @(posedge core_clk);
        check(compare_irq, 1'b1, "compare request");
        wr(FLG, 8'h02);
        repeat (3) @(posedge core_clk);
        check(compare_irq, 1'b0, "compare request");
    endtask : t_match

    task automatic t_force();
        logic [1:0] act[6] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
        logic [5:0] eo = 6'h13;
        wr(CTL, 8'h00);
        wr(CNT, 8'h07);
        wr(FLG, 8'h03);
        for (int i = 0; i < 6; i++) begin
            wr(CTL, cb(3'h0, 2'h2, act[i], 1'b1));
            repeat (3) @(posedge core_clk);
            check(compare_output, eo[i], "forced output");
        end
        rd_chk(FLG, 8'h00);
        rd_chk(CNT, 8'h07);
    endtask : t_force

    task automatic t_ctc();
        wr(CTL, 8'h00);
        wr(CMP, 8'h03);
        wr(CNT, 8'h01);
        wr(FLG, 8'h03);
        wr(CTL, cb(3'h7, 2'h2, 2'h0, 1'b0));
        pin_pulse(2);
        rd_chk(CNT, 8'h03);
        pin_pulse(1);
        rd_chk(CNT, 8'h00);
        rd_chk(FLG, 8'h02);
    endtask : t_ctc

    task automatic t_fpwm();
        wr(CTL, cb(3'h0, 2'h0, 2'h3, 1'b1));
        wr(CMP, 8'h20);
        wr(CTL, cb(3'h0, 2'h3, 2'h2, 1'b0));
        check(compare_output, 1'b1, "output kept");
        wr(CMP, 8'h12);
        rd_chk(CMP, 8'h12);
        wr(CNT, 8'h10);
        wr(FLG, 8'h03);
        wr(CTL, cb(3'h7, 2'h3, 2'h2, 1'b0));
        pin_pulse(3);
        rd_chk(FLG, 8'h00);
        check(compare_output, 1'b1, "output");
        wr(CNT, 8'hFE);
        pin_pulse(2);
        rd_chk(FLG, 8'h01);
        pin_pulse(19);
        rd_chk(FLG, 8'h03);
        check(compare_output, 1'b0, "cleared on match");
        pin_pulse(238);
        check(compare_output, 1'b1, "set at bottom");
    endtask : t_fpwm

    task automatic t_pcpwm();
        wr(CTL, 8'h00);
        wr(CNT, 8'hFE);
        wr(CTL, cb(3'h7, 2'h1, 2'h0, 1'b0));
        pin_pulse(2);
        rd_chk(CNT, 8'hFE);
        wr(CNT, 8'h02);
        wr(FLG, 8'h03);
        pin_pulse(3);
        rd_chk(CNT, 8'h01);
        rd_chk(FLG, 8'h01);
    endtask : t_pcpwm

    // ==========================================
    // main sequence and hang guards
    initial begin
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        ext_count_pin = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_edges();
        t_prescale();
        t_normal();
        t_match();
        t_force();
        t_ctc();
        t_fpwm();
        t_pcpwm();
        print_verdict();
    end

    always @(posedge bus_hang) begin
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
endmodule : test_eight_bit_timer_compare_unit
